// [rtl/csw_pkg.sv]
// Constants, register map and field layout of the clock sync and weekly scheduler.
// Assumes a single 125 MHz system clock and an Avalon-MM master with 32-bit data.
//
// How it works
// R01 - Log a time-changed event when an applied update moves time by over a minute or changes the date.
// R02 - Cloud answers load date and time directly, ignoring daylight mode and zone offset.
// R03 - In network-time mode query the time server every five minutes and apply replies.
// R04 - Daylight mode 0 leaves network time unchanged, mode 1 adds one hour.
// R05 - Daylight mode 2 is summer time from 01:00 last March Sunday to last October Sunday.
// R06 - Daylight mode 3 follows calendar 15 and calendar 16 outputs.
// R07 - Zone offset is signed quarter hours, -47 to +48, added to reference time.
// R08 - Test weekday mask, Sunday bit 01 to Saturday bit 40, selects engine test days.
// R09 - On a test day the test starts at its time whatever the engine did before.
// R10 - Test starts at the common start time and lasts the programmed minutes.
// R11 - Auto-start weekday mask, Sunday 01 to Saturday 40, permits automatic start days.
// R12 - Automatic start is permitted only inside the common start to end slot.
// R13 - A start later than the end spans midnight into the following day.
// R14 - One automatic slot is shared by every selected day.
// R15 - Forcing weekday mask, Sunday 01 to Saturday 40, forces intervention on those days.
// R16 - Forcing runs from the forcing start to the forcing end on selected days.
// R17 - All windows are evaluated once per minute tick and qualifiers update synchronously.
package csw_pkg;
	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DST_MODE = 8'h04;
	localparam logic [7:0] REG_ZONE = 8'h08;
	localparam logic [7:0] REG_TEST_MASK = 8'h0c;
	localparam logic [7:0] REG_TEST_START = 8'h10;
	localparam logic [7:0] REG_TEST_DUR = 8'h14;
	localparam logic [7:0] REG_AUTO_MASK = 8'h18;
	localparam logic [7:0] REG_AUTO_START = 8'h1c;
	localparam logic [7:0] REG_AUTO_END = 8'h20;
	localparam logic [7:0] REG_FORCE_MASK = 8'h24;
	localparam logic [7:0] REG_FORCE_START = 8'h28;
	localparam logic [7:0] REG_FORCE_END = 8'h2c;
	localparam logic [7:0] REG_STATUS = 8'h30;
	localparam logic [7:0] REG_TIME = 8'h34;
	localparam logic [7:0] REG_DATE = 8'h38;
	// Field positions: time of day registers hold hours at HM_HOUR_LSB, minutes at bit 0.
	localparam int HM_HOUR_LSB = 8;
	localparam int TIME_MIN_LSB = 8;
	localparam int TIME_HOUR_LSB = 16;
	localparam int TIME_WDAY_LSB = 24;
	localparam int DATE_MONTH_LSB = 8;
	localparam int DATE_YEAR_LSB = 16;
	localparam int ST_CHANGED = 0;
	localparam int ST_DST = 1;
	localparam int ST_TEST = 4;
	localparam int ST_AUTO = 5;
	localparam int ST_FORCE = 6;
	// Reset values.
	localparam logic [1:0] DST_MODE_RST = 2'h0;
	localparam logic [7:0] ZONE_RST = 8'h00;
	localparam logic [6:0] MASK_RST = 7'h00;
	localparam logic [10:0] MOD_RST = 11'h000;
	localparam logic [9:0] DUR_RST = 10'h000;
	localparam logic [4:0] DAY_RST = 5'h01;
	localparam logic [3:0] MONTH_RST = 4'h1;
	// Limits.
	localparam logic signed [7:0] ZONE_MIN = -8'sd47;
	localparam logic signed [7:0] ZONE_MAX = 8'sd48;
	localparam int MIN_PER_DAY = 1440;
	localparam int QUARTER_MIN = 15;
	localparam int HOUR_MIN = 60;
	localparam int CHANGE_LIMIT_S = 60;
	localparam logic [4:0] LAST_SUNDAY_FIRST = 5'd25;
	localparam logic [3:0] MONTH_MARCH = 4'd3;
	localparam logic [3:0] MONTH_OCTOBER = 4'd10;
	localparam logic [4:0] DST_SWITCH_HOUR = 5'd1;
	// Timing: one second tick and the network query period.
	localparam int TICK_PERIOD_MS = 1000;
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int SEC_CYCLES = TICK_PERIOD_MS * CLK_FREQ_KHZ;
	localparam int NTP_PERIOD_MIN = 5;
	localparam int NTP_PERIOD_S = NTP_PERIOD_MIN * 60;
endpackage : csw_pkg

// [rtl/csw_scheduler.sv]
// Real-time counter with cloud and network-time resynchronisation and weekly schedule qualifiers.
// Assumes sync strobes and calendar bits come from logic on CLK; registers sit on Avalon-MM.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module csw_scheduler #(
	parameter int SEC_CYCLES = csw_pkg::SEC_CYCLES
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Avalon-MM slave.
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Received date and time, shared by both sources.
	input wire logic CLOUD_SYNC_VALID,
	input wire logic NTP_REPLY_VALID,
	input wire logic [5:0] SYNC_SEC,
	input wire logic [5:0] SYNC_MIN,
	input wire logic [4:0] SYNC_HOUR,
	input wire logic [2:0] SYNC_WDAY,
	input wire logic [4:0] SYNC_DAY,
	input wire logic [3:0] SYNC_MONTH,
	input wire logic [6:0] SYNC_YEAR,
	output logic NTP_QUERY,
	// Calendar bits for daylight mode 3.
	input wire logic CAL15_ACTIVE,
	input wire logic CAL16_ACTIVE,
	// Qualifiers and event.
	output logic TIME_CHANGED_EVENT,
	output logic TEST_RUN,
	output logic AUTO_START_PERMIT,
	output logic FORCE_RUN
);
	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [2:0] wday;
	} csw_date_t;

	function automatic logic [4:0] month_len(input logic [3:0] m, input logic [6:0] y);
		logic [4:0] n;
		n = 5'd31;
		if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11) begin
			n = 5'd30;
		end else if (m == 4'd2) begin
			n = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
		end
		return n;
	endfunction : month_len

	function automatic csw_date_t date_inc(input csw_date_t d);
		csw_date_t r;
		r = d;
		r.wday = (d.wday == 3'd6) ? 3'd0 : d.wday + 3'd1;
		if (d.day >= month_len(d.month, d.year)) begin
			r.day = 5'd1;
			if (d.month == 4'd12) begin
				r.month = 4'd1;
				r.year = (d.year == 7'd99) ? 7'd0 : d.year + 7'd1;
			end else begin
				r.month = d.month + 4'd1;
			end
		end else begin
			r.day = d.day + 5'd1;
		end
		return r;
	endfunction : date_inc

	function automatic csw_date_t date_dec(input csw_date_t d);
		csw_date_t r;
		r = d;
		r.wday = (d.wday == 3'd0) ? 3'd6 : d.wday - 3'd1;
		if (d.day <= 5'd1) begin
			if (d.month == 4'd1) begin
				r.month = 4'd12;
				r.year = (d.year == 7'd0) ? 7'd99 : d.year - 7'd1;
			end else begin
				r.month = d.month - 4'd1;
			end
			r.day = month_len(r.month, r.year);
		end else begin
			r.day = d.day - 5'd1;
		end
		return r;
	endfunction : date_dec

	// True once the last Sunday of a 31-day month has reached the switch hour.
	function automatic logic past_last_sunday(input csw_date_t d, input logic [4:0] h);
		logic r;
		r = ({1'b0, d.day} >= {3'b000, d.wday} + {1'b0, csw_pkg::LAST_SUNDAY_FIRST});
		if (d.wday == 3'd0 && d.day >= csw_pkg::LAST_SUNDAY_FIRST && h < csw_pkg::DST_SWITCH_HOUR) begin
			r = 1'b0;
		end
		return r;
	endfunction : past_last_sunday

	// Weekly window test; a start after the end spans midnight into the next day.
	function automatic logic in_window(input logic [6:0] mask, input logic [2:0] wd, input logic [11:0] mod,
			input logic [11:0] s, input logic [11:0] e);
		logic [2:0] prev;
		logic r;
		prev = (wd == 3'd0) ? 3'd6 : wd - 3'd1;
		if (s <= e) begin
			r = mask[wd] && mod >= s && mod < e;
		end else begin
			r = (mask[wd] && mod >= s) || (mask[prev] && mod < e);
		end
		return r;
	endfunction : in_window

	// Registers.
	logic ntp_mode, next_ntp_mode;
	logic [1:0] dst_mode, next_dst_mode;
	logic [7:0] zone, next_zone;
	logic [6:0] test_mask, next_test_mask, auto_mask, next_auto_mask, force_mask, next_force_mask;
	logic [10:0] test_start, next_test_start, auto_start, next_auto_start;
	logic [10:0] auto_end, next_auto_end, force_start, next_force_start, force_end, next_force_end;
	logic [9:0] test_dur, next_test_dur;
	logic changed_flag, next_changed_flag;
	logic [31:0] rdata, next_rdata;
	logic ack, next_ack;
	// Time counter.
	logic [26:0] presc, next_presc;
	logic [5:0] sec, next_sec, minute, next_minute;
	logic [4:0] hour, next_hour;
	csw_date_t date, next_date;
	logic [8:0] ntp_cnt, next_ntp_cnt;
	logic query, next_query;
	logic event_out, next_event_out;
	logic eval, next_eval;
	logic cal15_q, cal16_q, dst_cal, next_dst_cal;
	logic test_run, next_test_run, auto_ok, next_auto_ok, force_run, next_force_run;

	logic sec_tick, access, wr;
	logic dst_auto, dst_on;
	logic [11:0] mod_now, test_end;
	logic signed [12:0] adj;
	logic [10:0] sync_mod, new_mod;
	csw_date_t sync_date, new_date;
	logic [16:0] cur_s, new_s;

	assign access = (AVS_READ || AVS_WRITE) && !ack;
	assign wr = AVS_WRITE && ack;
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
	assign AVS_READDATA = rdata;
	assign sec_tick = (presc == 27'(SEC_CYCLES - 1));
	assign mod_now = 12'(hour * 60) + {6'h00, minute};
	assign test_end = {1'b0, test_start} + {2'b00, test_dur};
	assign NTP_QUERY = query;
	assign TIME_CHANGED_EVENT = event_out;
	assign TEST_RUN = test_run;
	assign AUTO_START_PERMIT = auto_ok;
	assign FORCE_RUN = force_run;

	// Daylight decision for network updates, taken on the current local date.
	always_comb begin
		dst_auto = (date.month > csw_pkg::MONTH_MARCH && date.month < csw_pkg::MONTH_OCTOBER);
		if (date.month == csw_pkg::MONTH_MARCH) begin
			dst_auto = past_last_sunday(date, hour); // R05
		end else if (date.month == csw_pkg::MONTH_OCTOBER) begin
			dst_auto = !past_last_sunday(date, hour); // R05
		end
		unique case (dst_mode)
			2'd0: dst_on = 1'b0; // R04
			2'd1: dst_on = 1'b1; // R04
			2'd2: dst_on = dst_auto; // R05
			2'd3: dst_on = dst_cal; // R06
		endcase
	end

	// Received reference time adjusted by zone and daylight, with day rollover, for network replies; cloud loads pass unadjusted.
	always_comb begin
		sync_date.year = SYNC_YEAR;
		sync_date.month = SYNC_MONTH;
		sync_date.day = SYNC_DAY;
		sync_date.wday = SYNC_WDAY;
		sync_mod = 11'(SYNC_HOUR * 60) + {5'h00, SYNC_MIN};
		adj = $signed({2'b00, sync_mod}) + 13'($signed(zone) * csw_pkg::QUARTER_MIN); // R07
		if (dst_on) begin
			adj = adj + 13'(csw_pkg::HOUR_MIN); // R04
		end
		new_date = sync_date;
		if (CLOUD_SYNC_VALID) begin
			adj = $signed({2'b00, sync_mod}); // R02
		end else if (adj < 0) begin
			adj = adj + 13'(csw_pkg::MIN_PER_DAY);
			new_date = date_dec(sync_date);
		end else if (adj >= 13'(csw_pkg::MIN_PER_DAY)) begin
			adj = adj - 13'(csw_pkg::MIN_PER_DAY);
			new_date = date_inc(sync_date);
		end
		new_mod = adj[10:0];
		cur_s = 17'(mod_now * 60) + {11'h000, sec};
		new_s = 17'(new_mod * 60) + {11'h000, SYNC_SEC};
	end

	// Register file and bus answer; one wait cycle on every access.
	always_comb begin
		next_ntp_mode = ntp_mode;
		next_dst_mode = dst_mode;
		next_zone = zone;
		next_test_mask = test_mask;
		next_test_start = test_start;
		next_test_dur = test_dur;
		next_auto_mask = auto_mask;
		next_auto_start = auto_start;
		next_auto_end = auto_end;
		next_force_mask = force_mask;
		next_force_start = force_start;
		next_force_end = force_end;
		next_ack = access;
		next_rdata = rdata;
		if (wr) begin
			unique case (AVS_ADDRESS)
				csw_pkg::REG_CTRL: next_ntp_mode = AVS_WRITEDATA[0];
				csw_pkg::REG_DST_MODE: next_dst_mode = AVS_WRITEDATA[1:0];
				csw_pkg::REG_ZONE: begin
					if ($signed(AVS_WRITEDATA[7:0]) >= csw_pkg::ZONE_MIN
							&& $signed(AVS_WRITEDATA[7:0]) <= csw_pkg::ZONE_MAX) begin
						next_zone = AVS_WRITEDATA[7:0]; // R07
					end
				end
				csw_pkg::REG_TEST_MASK: next_test_mask = AVS_WRITEDATA[6:0]; // R08
				csw_pkg::REG_TEST_START: next_test_start = 11'(AVS_WRITEDATA[12:8] * 60) + {5'h00, AVS_WRITEDATA[5:0]};
				csw_pkg::REG_TEST_DUR: next_test_dur = AVS_WRITEDATA[9:0]; // R10
				csw_pkg::REG_AUTO_MASK: next_auto_mask = AVS_WRITEDATA[6:0]; // R11
				csw_pkg::REG_AUTO_START: next_auto_start = 11'(AVS_WRITEDATA[12:8] * 60) + {5'h00, AVS_WRITEDATA[5:0]};
				csw_pkg::REG_AUTO_END: next_auto_end = 11'(AVS_WRITEDATA[12:8] * 60) + {5'h00, AVS_WRITEDATA[5:0]};
				csw_pkg::REG_FORCE_MASK: next_force_mask = AVS_WRITEDATA[6:0]; // R15
				csw_pkg::REG_FORCE_START: next_force_start = 11'(AVS_WRITEDATA[12:8] * 60) + {5'h00, AVS_WRITEDATA[5:0]};
				csw_pkg::REG_FORCE_END: next_force_end = 11'(AVS_WRITEDATA[12:8] * 60) + {5'h00, AVS_WRITEDATA[5:0]};
				default: begin
				end
			endcase
		end
		if (AVS_READ && !ack) begin
			unique case (AVS_ADDRESS)
				csw_pkg::REG_CTRL: next_rdata = {31'h00000000, ntp_mode};
				csw_pkg::REG_DST_MODE: next_rdata = {30'h00000000, dst_mode};
				csw_pkg::REG_ZONE: next_rdata = {24'h000000, zone};
				csw_pkg::REG_TEST_MASK: next_rdata = {25'h0000000, test_mask};
				csw_pkg::REG_TEST_START: next_rdata = {19'h00000, 5'(test_start / 60), 2'h0, 6'(test_start % 60)};
				csw_pkg::REG_TEST_DUR: next_rdata = {22'h000000, test_dur};
				csw_pkg::REG_AUTO_MASK: next_rdata = {25'h0000000, auto_mask};
				csw_pkg::REG_AUTO_START: next_rdata = {19'h00000, 5'(auto_start / 60), 2'h0, 6'(auto_start % 60)};
				csw_pkg::REG_AUTO_END: next_rdata = {19'h00000, 5'(auto_end / 60), 2'h0, 6'(auto_end % 60)};
				csw_pkg::REG_FORCE_MASK: next_rdata = {25'h0000000, force_mask};
				csw_pkg::REG_FORCE_START: next_rdata = {19'h00000, 5'(force_start / 60), 2'h0, 6'(force_start % 60)};
				csw_pkg::REG_FORCE_END: next_rdata = {19'h00000, 5'(force_end / 60), 2'h0, 6'(force_end % 60)};
				csw_pkg::REG_STATUS: next_rdata = {25'h0000000, force_run, auto_ok, test_run, 2'h0, dst_on, changed_flag};
				csw_pkg::REG_TIME: next_rdata = {5'h00, date.wday, 3'h0, hour, 2'h0, minute, 2'h0, sec};
				csw_pkg::REG_DATE: next_rdata = {9'h000, date.year, 4'h0, date.month, 3'h0, date.day};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	// Time counter, resynchronisation, query timer and daylight calendar latch.
	always_comb begin
		next_presc = sec_tick ? 27'h0000000 : presc + 27'h0000001;
		next_sec = sec;
		next_minute = minute;
		next_hour = hour;
		next_date = date;
		next_ntp_cnt = ntp_cnt;
		next_query = 1'b0;
		next_event_out = 1'b0;
		next_eval = 1'b0;
		next_changed_flag = changed_flag;
		next_dst_cal = dst_cal;
		if (CAL15_ACTIVE && !cal15_q) begin
			next_dst_cal = 1'b1; // R06
		end else if (CAL16_ACTIVE && !cal16_q) begin
			next_dst_cal = 1'b0; // R06
		end
		if (sec_tick) begin
			next_sec = (sec == 6'd59) ? 6'd0 : sec + 6'd1;
			if (sec == 6'd59) begin
				next_eval = 1'b1; // R17
				next_minute = (minute == 6'd59) ? 6'd0 : minute + 6'd1;
				if (minute == 6'd59) begin
					next_hour = (hour == 5'd23) ? 5'd0 : hour + 5'd1;
					if (hour == 5'd23) begin
						next_date = date_inc(date);
					end
				end
			end
			if (ntp_mode) begin
				next_ntp_cnt = (ntp_cnt == 9'(csw_pkg::NTP_PERIOD_S - 1)) ? 9'h000 : ntp_cnt + 9'h001;
				next_query = (ntp_cnt == 9'(csw_pkg::NTP_PERIOD_S - 1)); // R03
			end
		end
		if (!ntp_mode) begin
			next_ntp_cnt = 9'h000;
		end
		if (CLOUD_SYNC_VALID || (NTP_REPLY_VALID && ntp_mode)) begin
			next_presc = CLOUD_SYNC_VALID ? 27'h0000000 : next_presc; // R03
			next_sec = SYNC_SEC;
			next_minute = 6'(new_mod % 60); // R02 R03
			next_hour = 5'(new_mod / 60);
			next_date = new_date;
			next_eval = 1'b1;
			if (new_date != date || (new_s > cur_s ? new_s - cur_s : cur_s - new_s) > 17'(csw_pkg::CHANGE_LIMIT_S)) begin
				next_event_out = 1'b1; // R01
			end
		end else if (wr && AVS_ADDRESS == csw_pkg::REG_TIME) begin
			next_presc = 27'h0000000;
			next_sec = AVS_WRITEDATA[5:0];
			next_minute = AVS_WRITEDATA[13:8];
			next_hour = AVS_WRITEDATA[20:16];
			next_date.wday = AVS_WRITEDATA[26:24];
			next_eval = 1'b1;
		end else if (wr && AVS_ADDRESS == csw_pkg::REG_DATE) begin
			next_date.day = AVS_WRITEDATA[4:0];
			next_date.month = AVS_WRITEDATA[11:8];
			next_date.year = AVS_WRITEDATA[22:16];
			next_eval = 1'b1;
		end
		if (wr && AVS_ADDRESS == csw_pkg::REG_STATUS && AVS_WRITEDATA[csw_pkg::ST_CHANGED]) begin
			next_changed_flag = 1'b0;
		end
		if (next_event_out) begin
			next_changed_flag = 1'b1; // R01
		end
	end

	// Schedule qualifiers, refreshed only on an evaluation tick.
	always_comb begin
		next_test_run = test_run;
		next_auto_ok = auto_ok;
		next_force_run = force_run;
		if (eval) begin
			next_test_run = in_window(test_mask, date.wday, mod_now, {1'b0, test_start}, // R08 R09 R10
				(test_end >= 12'(csw_pkg::MIN_PER_DAY)) ? test_end - 12'(csw_pkg::MIN_PER_DAY) : test_end);
			next_auto_ok = in_window(auto_mask, date.wday, mod_now, {1'b0, auto_start}, {1'b0, auto_end}); // R11 R12 R13 R14
			next_force_run = in_window(force_mask, date.wday, mod_now, {1'b0, force_start}, {1'b0, force_end}); // R15 R16
			if (test_dur == 10'h000) begin
				next_test_run = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ntp_mode <= 1'b0;
			dst_mode <= csw_pkg::DST_MODE_RST;
			zone <= csw_pkg::ZONE_RST;
			test_mask <= csw_pkg::MASK_RST;
			test_start <= csw_pkg::MOD_RST;
			test_dur <= csw_pkg::DUR_RST;
			auto_mask <= csw_pkg::MASK_RST;
			auto_start <= csw_pkg::MOD_RST;
			auto_end <= csw_pkg::MOD_RST;
			force_mask <= csw_pkg::MASK_RST;
			force_start <= csw_pkg::MOD_RST;
			force_end <= csw_pkg::MOD_RST;
			changed_flag <= 1'b0;
			rdata <= 32'h00000000;
			ack <= 1'b0;
			presc <= 27'h0000000;
			sec <= 6'h00;
			minute <= 6'h00;
			hour <= 5'h00;
			date <= '{year: 7'h00, month: csw_pkg::MONTH_RST, day: csw_pkg::DAY_RST, wday: 3'h0};
			ntp_cnt <= 9'h000;
			query <= 1'b0;
			event_out <= 1'b0;
			eval <= 1'b0;
			cal15_q <= 1'b0;
			cal16_q <= 1'b0;
			dst_cal <= 1'b0;
			test_run <= 1'b0;
			auto_ok <= 1'b0;
			force_run <= 1'b0;
		end else begin
			ntp_mode <= next_ntp_mode;
			dst_mode <= next_dst_mode;
			zone <= next_zone;
			test_mask <= next_test_mask;
			test_start <= next_test_start;
			test_dur <= next_test_dur;
			auto_mask <= next_auto_mask;
			auto_start <= next_auto_start;
			auto_end <= next_auto_end;
			force_mask <= next_force_mask;
			force_start <= next_force_start;
			force_end <= next_force_end;
			changed_flag <= next_changed_flag;
			rdata <= next_rdata;
			ack <= next_ack;
			presc <= next_presc;
			sec <= next_sec;
			minute <= next_minute;
			hour <= next_hour;
			date <= next_date;
			ntp_cnt <= next_ntp_cnt;
			query <= next_query;
			event_out <= next_event_out;
			eval <= next_eval;
			cal15_q <= CAL15_ACTIVE;
			cal16_q <= CAL16_ACTIVE;
			dst_cal <= next_dst_cal;
			test_run <= next_test_run;
			auto_ok <= next_auto_ok;
			force_run <= next_force_run;
		end
	end
endmodule : csw_scheduler

// [testbench/csw_scheduler_properties.sv]
// Checker of bus handshake, time-changed event and query pacing.
// Bound to every csw_scheduler; sees only its ports.
`timescale 1ns/100ps
module csw_properties #(
	parameter int SEC_CYCLES = 10
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Register bus.
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Sync, query and event.
	input wire logic CLOUD_SYNC_VALID,
	input wire logic NTP_REPLY_VALID,
	input wire logic NTP_QUERY,
	input wire logic TIME_CHANGED_EVENT
);
	localparam int QPER = csw_pkg::NTP_PERIOD_S * SEC_CYCLES;
	// Cycles since the last query, saturating.
	int gap;
	int next_gap;
	always_comb begin
		next_gap = NTP_QUERY ? 0 : (gap < QPER ? gap + 1 : gap);
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			gap <= QPER;
		end else begin
			gap <= next_gap;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	wait_first_a: assert property ($rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST)
		else $error("request answered at once");
	wait_once_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request not answered next cycle");
	wait_idle_a: assert property (AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
		else $error("waitrequest without request");
	read_hold_a: assert property (!$stable(AVS_READDATA) |-> $past(AVS_READ && AVS_WAITREQUEST))
		else $error("read data moved without read");
	event_cause_a: assert property (TIME_CHANGED_EVENT |-> $past(CLOUD_SYNC_VALID || NTP_REPLY_VALID))
		else $error("event without sync");
	write_quiet_a: assert property (AVS_WRITE && !(CLOUD_SYNC_VALID || NTP_REPLY_VALID) |=> !TIME_CHANGED_EVENT)
		else $error("event after bus write");
	query_pulse_a: assert property (NTP_QUERY |=> !NTP_QUERY [*8])
		else $error("query repeated");
	query_gap_a: assert property (NTP_QUERY |-> gap >= QPER - 1)
		else $error("query period too short");
endmodule : csw_properties
bind csw_scheduler csw_properties #(.SEC_CYCLES(SEC_CYCLES)) u_props (.CLK(CLK), .RST(RST), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.CLOUD_SYNC_VALID(CLOUD_SYNC_VALID), .NTP_REPLY_VALID(NTP_REPLY_VALID), .NTP_QUERY(NTP_QUERY),
	.TIME_CHANGED_EVENT(TIME_CHANGED_EVENT));

// [testbench/csw_ntp_model.sv]
// Time server model: answers each query with its reference stamp lat+1 cycles after sampling it.
// Assumes a one-cycle query on the same clock; stamp is {wday,hour,min,sec,day,month,year}.
`timescale 1ns/100ps
module csw_ntp_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Query, delay and reference time.
	input wire logic query,
	input wire logic [7:0] lat,
	input wire logic [35:0] ref_stamp,
	// Reply.
	output logic reply,
	output logic [35:0] stamp
);
	logic [7:0] cnt;
	logic busy;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			reply <= 1'b0;
			stamp <= 36'h0;
		end else begin
			reply <= 1'b0;
			// A released bus never keeps the last stamp.
			stamp <= ~stamp;
			if (query) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'b0;
				reply <= 1'b1;
				stamp <= ref_stamp;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule : csw_ntp_model

// [testbench/testbench.sv]
// Self-checking bench for the clock sync and weekly scheduler.
// Assumes the checker is bound to the design and the time server model answers queries.
`timescale 1ns/100ps
module testbench;
	localparam int SEC = 10;
	logic clk;
	logic rst;
	logic [7:0] adr;
	logic rd_en;
	logic wr_en;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic wait_req;
	logic cloud_valid;
	logic [35:0] cloud_stamp;
	logic [35:0] ref_stamp;
	logic [35:0] ntp_stamp;
	logic [35:0] stamp;
	logic [7:0] lat;
	logic ntp_reply;
	logic ntp_query;
	logic cal15;
	logic cal16;
	logic time_changed;
	logic test_run;
	logic auto_run;
	logic force_run;
	int fails;
	int checked;
	int cyc = 0;
	assign stamp = ntp_reply ? ntp_stamp : cloud_stamp;
	csw_scheduler #(.SEC_CYCLES(SEC)) u_dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
		.CLOUD_SYNC_VALID(cloud_valid), .NTP_REPLY_VALID(ntp_reply), .SYNC_SEC(stamp[21:16]),
		.SYNC_MIN(stamp[27:22]), .SYNC_HOUR(stamp[32:28]), .SYNC_WDAY(stamp[35:33]), .SYNC_DAY(stamp[15:11]),
		.SYNC_MONTH(stamp[10:7]), .SYNC_YEAR(stamp[6:0]), .NTP_QUERY(ntp_query), .CAL15_ACTIVE(cal15),
		.CAL16_ACTIVE(cal16), .TIME_CHANGED_EVENT(time_changed), .TEST_RUN(test_run),
		.AUTO_START_PERMIT(auto_run), .FORCE_RUN(force_run));
	csw_ntp_model u_ntp (.clk(clk), .rst(rst), .query(ntp_query), .lat(lat), .ref_stamp(ref_stamp),
		.reply(ntp_reply), .stamp(ntp_stamp));
	function automatic logic [35:0] mk(input logic [2:0] w, input logic [4:0] h, input logic [5:0] m,
		input logic [5:0] s, input logic [3:0] mo);
		return {w, h, m, s, 5'h0f, mo, 7'h18};
	endfunction : mk
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		adr <= a;
		wdat <= d;
		wr_en <= w;
		rd_en <= !w;
		do @(posedge clk); while (wait_req !== 1'b0);
		q = rdat;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	// Pulses a cloud load and reports whether the event followed within three cycles.
	task automatic cloud(input logic [35:0] s, output logic ev);
		cloud_stamp <= s;
		cloud_valid <= 1'b1;
		@(posedge clk);
		cloud_valid <= 1'b0;
		cloud_stamp <= ~s;
		ev = 1'b0;
		repeat (3) begin
			@(posedge clk);
			ev |= time_changed;
		end
	endtask : cloud
	task automatic t_regs();
		logic [31:0] q;
		logic [23:0] t [9] = '{24'h0c7f7f, 24'h185555, 24'h242a2a, 24'h083030, 24'h083130, 24'h08d1d1,
			24'h08d0d1, 24'h3cff00, 24'h040303};
		foreach (t[i]) begin
			wr(t[i][23:16], {24'h0, t[i][15:8]});
			bus(1'b0, t[i][23:16], 32'h0, q);
			chk("register", q, {24'h0, t[i][7:0]});
		end
		$display("register test done");
	endtask : t_regs
	task automatic t_event();
		logic [31:0] q;
		logic ev;
		wr(csw_pkg::REG_DST_MODE, 32'h1);
		wr(csw_pkg::REG_ZONE, 32'h4);
		cloud(mk(3'h1, 5'h0a, 6'h14, 6'h00, 4'h2), ev);
		chk("event on jump", ev, 1'b1);
		bus(1'b0, csw_pkg::REG_TIME, 32'h0, q);
		chk("cloud time", q[26:8], {3'h1, 3'h0, 5'h0a, 2'h0, 6'h14});
		bus(1'b0, csw_pkg::REG_STATUS, 32'h0, q);
		chk("status set", q[0], 1'b1);
		wr(csw_pkg::REG_STATUS, 32'h1);
		bus(1'b0, csw_pkg::REG_STATUS, 32'h0, q);
		chk("status cleared", q[0], 1'b0);
		cloud(mk(3'h1, 5'h0a, 6'h14, 6'h32, 4'h2), ev);
		chk("event small step", ev, 1'b0);
		cloud(mk(3'h1, 5'h0a, 6'h16, 6'h32, 4'h2), ev);
		chk("event large step", ev, 1'b1);
		$display("event test done");
	endtask : t_event
	task automatic t_sched();
		logic ev;
		logic [23:0] r [9] = '{24'h0c0012, 24'h100800, 24'h14001e, 24'h180002, 24'h1c1600, 24'h200600,
			24'h240010, 24'h280900, 24'h2c0a00};
		logic [16:0] p [14] = '{{8'h28, 6'h00, 3'h4}, {8'h28, 6'h1d, 3'h4}, {8'h28, 6'h1e, 3'h0},
			{8'h48, 6'h00, 3'h0}, {8'h88, 6'h0a, 3'h4}, {8'h36, 6'h00, 3'h2}, {8'h35, 6'h3b, 3'h0},
			{8'h45, 6'h3b, 3'h2}, {8'h46, 6'h00, 3'h0}, {8'h56, 6'h1e, 3'h0}, {8'h25, 6'h00, 3'h0},
			{8'h89, 6'h00, 3'h1}, {8'h89, 6'h3b, 3'h1}, {8'h8a, 6'h00, 3'h0}};
		foreach (r[i]) wr(r[i][23:16], {16'h0, r[i][15:0]});
		foreach (p[i]) begin
			cloud(mk(p[i][16:14], p[i][13:9], p[i][8:3], 6'h00, 4'h2), ev);
			@(posedge clk);
			chk("qualifiers", {test_run, auto_run, force_run}, p[i][2:0]);
		end
		cloud(mk(3'h1, 5'h07, 6'h3b, 6'h3a, 4'h2), ev);
		chk("test before rollover", test_run, 1'b0);
		repeat (25) @(posedge clk);
		chk("test after rollover", test_run, 1'b1);
		$display("schedule test done");
	endtask : t_sched
	task automatic t_ntp();
		logic [31:0] q;
		int t0;
		logic [28:0] c [8] = '{{12'h000, 4'h1, 2'h0, 11'h280}, {12'h5fc, 4'h1, 2'h0, 11'h29e},
			{12'h060, 4'h1, 2'h0, 11'h580}, {12'h1a2, 4'h1, 2'h0, 11'h58f}, {12'h800, 4'h7, 2'h0, 11'h2c0},
			{12'h800, 4'h1, 2'h0, 11'h280}, {12'hc00, 4'h1, 2'h2, 11'h2c0}, {12'hc00, 4'h7, 2'h1, 11'h280}};
		t0 = 0;
		wr(csw_pkg::REG_CTRL, 32'h1);
		foreach (c[i]) begin
			wr(csw_pkg::REG_DST_MODE, {30'h0, c[i][28:27]});
			wr(csw_pkg::REG_ZONE, {24'h0, c[i][25:18]});
			wr(csw_pkg::REG_DATE, {9'h0, 7'h18, 4'h0, c[i][16:13], 8'h0f});
			cal15 <= c[i][12];
			cal16 <= c[i][11];
			@(posedge clk);
			cal15 <= 1'b0;
			cal16 <= 1'b0;
			ref_stamp <= mk(3'h3, 5'h0a, 6'h00, 6'h00, c[i][16:13]);
			lat <= i[0] ? 8'h28 : 8'h01;
			while (ntp_query !== 1'b1) @(posedge clk);
			if (i > 0) chk("query period", cyc - t0, csw_pkg::NTP_PERIOD_S * SEC);
			t0 = cyc;
			repeat (60) @(posedge clk);
			bus(1'b0, csw_pkg::REG_TIME, 32'h0, q);
			chk("local time", {q[20:16], q[13:8]}, c[i][10:0]);
		end
		$display("network time test done");
	endtask : t_ntp
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 45000) begin
			fails++;
			$display("[ERR] run length expected below %0d seen %0d", 45000, cyc);
			print_verdict();
		end
	end
	initial begin
		rst = 1'b1;
		adr = 8'h00;
		rd_en = 1'b0;
		wr_en = 1'b0;
		wdat = 32'h0;
		cloud_valid = 1'b0;
		cloud_stamp = 36'h0;
		ref_stamp = 36'h0;
		lat = 8'h01;
		cal15 = 1'b0;
		cal16 = 1'b0;
		fails = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_event();
		t_sched();
		t_ntp();
		print_verdict();
	end
endmodule : testbench
